// ==== logic/tlig_pkg.sv ====
/*
 * Shared definitions for the three-level interrupt gating block: bit
 * positions inside the peripheral control registers, module mask bit
 * positions, reset values, the request state encoding and the carriers.
 * Assumes a single system clock and that every peripheral register is
 * presented to the block as a plain parallel value.
 */
package tlig_pkg;

	////////////////////////////////////////////////////////////////////////
	// vector and control register
	localparam logic [15:0] VECTOR_RESET = 16'h0000;
	localparam int GLOBAL_ENABLE_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// module mask bit positions
	localparam int MASK_MOD0_BIT = 0;
	localparam int MASK_MOD1_BIT = 1;
	localparam int MASK_MOD2_BIT = 2;
	localparam int MASK_MOD3_BIT = 3;
	localparam int MASK_MOD4_BIT = 4;
	localparam int MASK_SYSTEM_BIT = 7;
	localparam logic [7:0] MASK_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// local enable and flag positions inside peripheral registers
	localparam int WDOG_ENABLE_BIT = 6;
	localparam int WDOG_FLAG_BIT = 3;
	localparam int TOD_ENABLE_BIT = 1;
	localparam int SUBSEC_ENABLE_BIT = 2;
	localparam int TOD_FLAG_BIT = 6;
	localparam int SUBSEC_FLAG_BIT = 7;
	localparam int SERIAL_ENABLE_BIT = 2;
	localparam int SERIAL_RX_FLAG_BIT = 0;
	localparam int SERIAL_TX_FLAG_BIT = 1;
	localparam int SPI_ENABLE_BIT = 7;
	localparam int SPI_FAULT_FLAG_BIT = 3;
	localparam int SPI_COLLIDE_FLAG_BIT = 4;
	localparam int SPI_OVERRUN_FLAG_BIT = 5;
	localparam int SPI_DONE_FLAG_BIT = 6;
	localparam int TIMER_ENABLE_BIT = 7;
	localparam int TIMER_LCMP_FLAG_BIT = 0;
	localparam int TIMER_CAPT_FLAG_BIT = 1;
	localparam int TIMER_LOVF_FLAG_BIT = 2;
	localparam int TIMER_OVF_FLAG_BIT = 3;

	////////////////////////////////////////////////////////////////////////
	// request sequencer states, gray along idle -> pending -> service
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PEND = 2'b01,
		ST_SERV = 2'b11
	} tlig_state_type;

	// one bit per interrupt source: flags, set strobes, clear strobes
	typedef struct packed {
		logic [7:0] ext_lo;
		logic [7:0] ext_hi;
		logic tod_alarm;
		logic subsec_alarm;
		logic ser0_rx;
		logic ser0_tx;
		logic ser1_rx;
		logic ser1_tx;
		logic spi_fault;
		logic spi_collide;
		logic spi_overrun;
		logic spi_done;
		logic t0_low_cmp;
		logic t0_low_ovf;
		logic t0_capt;
		logic t0_ovf;
		logic t1_low_cmp;
		logic t1_low_ovf;
		logic wdog;
	} tlig_src_type;

	// peripheral registers that hold the local enables
	typedef struct packed {
		logic [7:0] ext_enable_lo;
		logic [7:0] ext_enable_hi;
		logic [7:0] watchdog_control;
		logic [15:0] rtc_control;
		logic [7:0] serial0_mode;
		logic [7:0] serial1_mode;
		logic [7:0] spi_config;
		logic [7:0] timer0_control_a;
		logic [7:0] timer0_control_b;
		logic [7:0] timer1_control_b;
	} tlig_en_type;

endpackage

// ==== logic/tlig_gate.sv ====
/*
 * One module-level gate: ORs flag AND local enable over the module's
 * sources and qualifies the result with the module mask bit.
 * Assumes flags and enables arrive already aligned bit for bit.
 */
module tlig_gate #(
	parameter int N = 1
) (
	input wire logic [N-1:0] flags_in,
	input wire logic [N-1:0] enables_in,
	input wire logic module_enable_in,
	output logic req_out
);

	// pure combinational; the caller registers what it exports
	assign req_out = module_enable_in & (|(flags_in & enables_in));

endmodule

// ==== logic/tlig_top.sv ====
/*
 * Top of the three-level interrupt gating block. Holds every source flag,
 * the vector register and the in-service bit, and offers one request to
 * the core sequencer with a single shared vector.
 * Assumes all inputs are synchronous to clk_in, software strobes are one
 * cycle wide, and the core acknowledges only while int_req_out is high.
 */

// What this block does
// [R1] all sources equal priority; one vector register, reset value zero
// [R2] module mask bit low blocks that module; high passes unless global off
// [R3] local enable high: flag raises request, however it was set
// [R4] hardware sets flags, never clears; software clears; set beats clear
// [R5] take needs global, module, local enable, flag high, in-service low
// [R6] global enable is bit zero of the interrupt control register
// [R7] in-service set on vectoring, cleared by return or pop-and-clear
// [R8] software clears in-service inside a handler only to allow nesting
// [R9] watchdog: mask bit seven, enable bit six, flag bit three
// [R10] external 0..7: mask bit zero, enable and flag bit n of low regs
// [R11] external 8..15: mask bit one, bit n-8 of high registers
// [R12] rtc alarms under mask bit zero; enables bits 1,2; flags bits 6,7
// [R13] serial 0 rx/tx under mask bit two, shared enable mode bit two
// [R14] serial 1 rx/tx under mask bit three, shared enable mode bit two
// [R15] four spi flags under mask bit three, enable config bit seven
// [R16] timer 0 low compare/overflow: mask three, enable b bit seven
// [R17] timer 0 capture/overflow: mask three, enable a bit seven
// [R18] timer 1 low compare/overflow: mask four, enable b bit seven
// [R19] module request is OR of flag AND enable; system gates that
// [R20] simultaneous sources share one vector; handler reads the flags
module tlig_top
	import tlig_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire tlig_src_type flag_event_in,
	input wire tlig_src_type flag_set_sw_in,
	input wire tlig_src_type flag_clr_sw_in,
	input wire tlig_en_type enables_in,
	input wire logic [7:0] module_mask_in,
	input wire logic [7:0] int_control_in,
	input wire logic vector_wr_in,
	input wire logic [15:0] vector_data_in,
	input wire logic core_ack_in,
	input wire logic return_op_in,
	input wire logic in_service_clr_in,
	output tlig_src_type flags_out,
	output logic [7:0] ext_flag_lo_out,
	output logic [7:0] ext_flag_hi_out,
	output logic [7:0] watchdog_flags_out,
	output logic [7:0] rtc_flags_out,
	output logic [7:0] serial0_flags_out,
	output logic [7:0] serial1_flags_out,
	output logic [7:0] spi_flags_out,
	output logic [7:0] timer0_flags_out,
	output logic [7:0] timer1_flags_out,
	output logic [7:0] module_req_out,
	output logic int_req_out,
	output logic vector_take_out,
	output logic [15:0] vector_addr_out,
	output logic in_service_out
);

	////////////////////////////////////////////////////////////////////////
	// helper functions

	// spreads the peripheral enable bits onto the per-source layout
	function automatic tlig_src_type local_enables(input tlig_en_type e);
		tlig_src_type r;
		r = '0;
		r.ext_lo = e.ext_enable_lo; // see [R10]
		r.ext_hi = e.ext_enable_hi; // see [R11]
		r.tod_alarm = e.rtc_control[TOD_ENABLE_BIT]; // see [R12]
		r.subsec_alarm = e.rtc_control[SUBSEC_ENABLE_BIT]; // see [R12]
		r.ser0_rx = e.serial0_mode[SERIAL_ENABLE_BIT]; // see [R13]
		r.ser0_tx = e.serial0_mode[SERIAL_ENABLE_BIT]; // see [R13]
		r.ser1_rx = e.serial1_mode[SERIAL_ENABLE_BIT]; // see [R14]
		r.ser1_tx = e.serial1_mode[SERIAL_ENABLE_BIT]; // see [R14]
		r.spi_fault = e.spi_config[SPI_ENABLE_BIT]; // see [R15]
		r.spi_collide = e.spi_config[SPI_ENABLE_BIT]; // see [R15]
		r.spi_overrun = e.spi_config[SPI_ENABLE_BIT]; // see [R15]
		r.spi_done = e.spi_config[SPI_ENABLE_BIT]; // see [R15]
		r.t0_low_cmp = e.timer0_control_b[TIMER_ENABLE_BIT]; // see [R16]
		r.t0_low_ovf = e.timer0_control_b[TIMER_ENABLE_BIT]; // see [R16]
		r.t0_capt = e.timer0_control_a[TIMER_ENABLE_BIT]; // see [R17]
		r.t0_ovf = e.timer0_control_a[TIMER_ENABLE_BIT]; // see [R17]
		r.t1_low_cmp = e.timer1_control_b[TIMER_ENABLE_BIT]; // see [R18]
		r.t1_low_ovf = e.timer1_control_b[TIMER_ENABLE_BIT]; // see [R18]
		r.wdog = e.watchdog_control[WDOG_ENABLE_BIT]; // see [R9]
		return r;
	endfunction

	// places four flags of a timer at their control register positions
	function automatic logic [7:0] timer_view(input logic lcmp,
		input logic capt, input logic lovf, input logic ovf);
		logic [7:0] v;
		v = 8'h00;
		v[TIMER_LCMP_FLAG_BIT] = lcmp;
		v[TIMER_CAPT_FLAG_BIT] = capt;
		v[TIMER_LOVF_FLAG_BIT] = lovf;
		v[TIMER_OVF_FLAG_BIT] = ovf;
		return v;
	endfunction

	// places the two flags of a serial port at their control positions
	function automatic logic [7:0] serial_view(input logic rx,
		input logic tx);
		logic [7:0] v;
		v = 8'h00;
		v[SERIAL_RX_FLAG_BIT] = rx;
		v[SERIAL_TX_FLAG_BIT] = tx;
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	tlig_src_type flags;
	tlig_src_type next_flags;
	tlig_src_type src_enable;
	tlig_state_type state;
	tlig_state_type next_state;
	logic [7:0] mreq;
	logic global_int_enable;
	logic in_service_bit;
	logic sys_req;
	logic [15:0] vector_address_reg;

	////////////////////////////////////////////////////////////////////////
	// source flags

	// a hardware event or a software set in the same cycle as a software
	// clear leaves the flag set, so no event is ever dropped
	always_comb begin
		next_flags = (flags & ~flag_clr_sw_in) | flag_set_sw_in
			| flag_event_in; // see [R4] see [R3]
	end

	// hardware only ever sets; nothing here clears without software
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags <= '0;
		end else begin
			flags <= next_flags; // see [R4]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// module gates

	assign src_enable = local_enables(enables_in);

	// module 0: external 0..7 plus both rtc alarms
	tlig_gate #(.N(10)) gate_mod0 (
		.flags_in({flags.ext_lo, flags.tod_alarm, flags.subsec_alarm}),
		.enables_in({src_enable.ext_lo, src_enable.tod_alarm,
			src_enable.subsec_alarm}),
		.module_enable_in(module_mask_in[MASK_MOD0_BIT]), // see [R10] see [R12]
		.req_out(mreq[MASK_MOD0_BIT])
	);

	// module 1: external 8..15
	tlig_gate #(.N(8)) gate_mod1 (
		.flags_in(flags.ext_hi),
		.enables_in(src_enable.ext_hi),
		.module_enable_in(module_mask_in[MASK_MOD1_BIT]), // see [R11]
		.req_out(mreq[MASK_MOD1_BIT])
	);

	// module 2: serial port 0
	tlig_gate #(.N(2)) gate_mod2 (
		.flags_in({flags.ser0_rx, flags.ser0_tx}),
		.enables_in({src_enable.ser0_rx, src_enable.ser0_tx}),
		.module_enable_in(module_mask_in[MASK_MOD2_BIT]), // see [R13]
		.req_out(mreq[MASK_MOD2_BIT])
	);

	// module 3: serial port 1, spi and timer 0 share one mask bit
	tlig_gate #(.N(10)) gate_mod3 (
		.flags_in({flags.ser1_rx, flags.ser1_tx, flags.spi_fault,
			flags.spi_collide, flags.spi_overrun, flags.spi_done,
			flags.t0_low_cmp, flags.t0_low_ovf, flags.t0_capt,
			flags.t0_ovf}),
		.enables_in({src_enable.ser1_rx, src_enable.ser1_tx,
			src_enable.spi_fault, src_enable.spi_collide,
			src_enable.spi_overrun, src_enable.spi_done,
			src_enable.t0_low_cmp, src_enable.t0_low_ovf,
			src_enable.t0_capt, src_enable.t0_ovf}),
		.module_enable_in(module_mask_in[MASK_MOD3_BIT]), // see [R14] see [R15]
		.req_out(mreq[MASK_MOD3_BIT])
	);

	// module 4: timer 1 low half
	tlig_gate #(.N(2)) gate_mod4 (
		.flags_in({flags.t1_low_cmp, flags.t1_low_ovf}),
		.enables_in({src_enable.t1_low_cmp, src_enable.t1_low_ovf}),
		.module_enable_in(module_mask_in[MASK_MOD4_BIT]), // see [R18]
		.req_out(mreq[MASK_MOD4_BIT])
	);

	// system module: watchdog
	tlig_gate #(.N(1)) gate_sys (
		.flags_in(flags.wdog),
		.enables_in(src_enable.wdog),
		.module_enable_in(module_mask_in[MASK_SYSTEM_BIT]), // see [R9]
		.req_out(mreq[MASK_SYSTEM_BIT])
	);

	// mask positions with no module behind them never request
	assign mreq[5] = 1'b0;
	assign mreq[6] = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// system request

	assign global_int_enable = int_control_in[GLOBAL_ENABLE_BIT]; // see [R6]
	assign in_service_bit = (state == ST_SERV);

	// all modules collapse into one request with no priority among them
	always_comb begin
		sys_req = global_int_enable & (|mreq)
			& ~in_service_bit; // see [R5] [R2] [R19] [R20]
	end

	////////////////////////////////////////////////////////////////////////
	// request sequencer

	// a request withdrawn before the ack (flag cleared, enable dropped)
	// returns to idle rather than vectoring on a stale cause
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (sys_req) begin
					next_state = ST_PEND;
				end
			end
			ST_PEND: begin
				if (core_ack_in) begin
					next_state = ST_SERV; // see [R7]
				end else if (!sys_req) begin
					next_state = ST_IDLE;
				end
			end
			ST_SERV: begin
				// software clear opens the window for a nested take
				if (return_op_in || in_service_clr_in) begin
					next_state = ST_IDLE; // see [R7] see [R8]
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// request and in-service flops mirror the next state for timing
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			int_req_out <= 1'b0;
			in_service_out <= 1'b0;
			vector_take_out <= 1'b0;
		end else begin
			int_req_out <= (next_state == ST_PEND); // see [R5]
			in_service_out <= (next_state == ST_SERV); // see [R7]
			vector_take_out <= (state == ST_PEND) && core_ack_in; // see [R1]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// vector register

	// one address for every source; a write lands on the next edge
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			vector_address_reg <= VECTOR_RESET; // see [R1]
		end else if (vector_wr_in) begin
			vector_address_reg <= vector_data_in;
		end
	end

	assign vector_addr_out = vector_address_reg;

	////////////////////////////////////////////////////////////////////////
	// status views

	// flags in their peripheral register layout so handler software can
	// find the cause; these lag flags_out by nothing, both are flops
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_out <= '0;
			ext_flag_lo_out <= 8'h00;
			ext_flag_hi_out <= 8'h00;
			watchdog_flags_out <= 8'h00;
			rtc_flags_out <= 8'h00;
			serial0_flags_out <= 8'h00;
			serial1_flags_out <= 8'h00;
			spi_flags_out <= 8'h00;
			timer0_flags_out <= 8'h00;
			timer1_flags_out <= 8'h00;
		end else begin
			flags_out <= next_flags; // see [R20]
			ext_flag_lo_out <= next_flags.ext_lo; // see [R10]
			ext_flag_hi_out <= next_flags.ext_hi; // see [R11]
			watchdog_flags_out <= 8'h00;
			watchdog_flags_out[WDOG_FLAG_BIT] <= next_flags.wdog; // see [R9]
			rtc_flags_out <= 8'h00;
			rtc_flags_out[TOD_FLAG_BIT] <= next_flags.tod_alarm; // see [R12]
			rtc_flags_out[SUBSEC_FLAG_BIT] <= next_flags.subsec_alarm;
			serial0_flags_out <= serial_view(next_flags.ser0_rx,
				next_flags.ser0_tx); // see [R13]
			serial1_flags_out <= serial_view(next_flags.ser1_rx,
				next_flags.ser1_tx); // see [R14]
			spi_flags_out <= 8'h00;
			spi_flags_out[SPI_FAULT_FLAG_BIT] <= next_flags.spi_fault; // see [R15]
			spi_flags_out[SPI_COLLIDE_FLAG_BIT] <= next_flags.spi_collide;
			spi_flags_out[SPI_OVERRUN_FLAG_BIT] <= next_flags.spi_overrun;
			spi_flags_out[SPI_DONE_FLAG_BIT] <= next_flags.spi_done;
			timer0_flags_out <= timer_view(next_flags.t0_low_cmp,
				next_flags.t0_capt, next_flags.t0_low_ovf,
				next_flags.t0_ovf); // see [R16] see [R17]
			timer1_flags_out <= timer_view(next_flags.t1_low_cmp, 1'b0,
				next_flags.t1_low_ovf, 1'b0); // see [R18]
		end
	end

	// gated module requests, for diagnosis and switchback style logic
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			module_req_out <= MASK_RESET;
		end else begin
			module_req_out <= mreq; // see [R2]
		end
	end

endmodule

// ==== tb/tlig_properties.sv ====
/*
 checker for the interrupt gating top, fed only by its ports.
 assumes one clock and an asynchronous active-high reset.
*/
module tlig_properties
	import tlig_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire tlig_src_type flag_event_in,
	input wire tlig_src_type flag_set_sw_in,
	input wire tlig_src_type flag_clr_sw_in,
	input wire tlig_en_type enables_in,
	input wire logic [7:0] module_mask_in,
	input wire logic [7:0] int_control_in,
	input wire logic vector_wr_in,
	input wire logic [15:0] vector_data_in,
	input wire logic core_ack_in,
	input wire logic return_op_in,
	input wire logic in_service_clr_in,
	input wire tlig_src_type flags_out,
	input wire logic [7:0] module_req_out,
	input wire logic int_req_out,
	input wire logic vector_take_out,
	input wire logic [15:0] vector_addr_out,
	input wire logic in_service_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////
	// set strobes win over clear, so a clear counts only alone
	tlig_src_type set_any;
	tlig_src_type clr_only;
	assign set_any = flag_event_in | flag_set_sw_in;
	assign clr_only = flag_clr_sw_in & ~set_any;
	chk_flag_sets: assert property (1'b1 |=>
		(flags_out & $past(set_any)) == $past(set_any))
		else $error("flag not set by strobe");
	chk_flag_keeps: assert property (1'b1 |=>
		(~flags_out & $past(flags_out & ~flag_clr_sw_in)) == '0)
		else $error("flag dropped without clear");
	chk_flag_clears: assert property (1'b1 |=>
		(flags_out & $past(clr_only)) == '0)
		else $error("flag not cleared");
	chk_wdog_gate: assert property (1'b1 |=>
		module_req_out[MASK_SYSTEM_BIT] == $past(flags_out.wdog &
		enables_in.watchdog_control[WDOG_ENABLE_BIT] &
		module_mask_in[MASK_SYSTEM_BIT]))
		else $error("watchdog module request wrong");
	chk_serial_gate: assert property (1'b1 |=>
		module_req_out[MASK_MOD2_BIT] == $past((flags_out.ser0_rx |
		flags_out.ser0_tx) & enables_in.serial0_mode[SERIAL_ENABLE_BIT] &
		module_mask_in[MASK_MOD2_BIT]))
		else $error("serial module request wrong");
	chk_req_gates: assert property ($rose(int_req_out) |->
		$past(int_control_in[GLOBAL_ENABLE_BIT]) && !$past(in_service_out))
		else $error("request raised with gate closed");
	chk_busy_quiet: assert property (in_service_out |-> !int_req_out)
		else $error("request while in service");
	chk_ack_take: assert property (int_req_out && core_ack_in |=>
		in_service_out && vector_take_out && !int_req_out)
		else $error("ack not taken");
	chk_take_cause: assert property (vector_take_out |->
		$past(int_req_out && core_ack_in))
		else $error("vector taken without ack");
	chk_exit_clears: assert property ((return_op_in ||
		in_service_clr_in) && !int_req_out |=> !in_service_out)
		else $error("in service not cleared");
	chk_vec_load: assert property (vector_wr_in |=>
		vector_addr_out == $past(vector_data_in))
		else $error("vector not loaded");
	chk_vec_keep: assert property (!vector_wr_in |=>
		$stable(vector_addr_out))
		else $error("vector changed");
	cov_take: cover property (vector_take_out);
	cov_nest: cover property (in_service_clr_in && in_service_out);
	cov_return: cover property (return_op_in && in_service_out);
endmodule

bind tlig_top tlig_properties chk (.clk_in, .rst_in, .flag_event_in,
	.flag_set_sw_in, .flag_clr_sw_in, .enables_in, .module_mask_in,
	.int_control_in, .vector_wr_in, .vector_data_in, .core_ack_in,
	.return_op_in, .in_service_clr_in, .flags_out, .module_req_out,
	.int_req_out, .vector_take_out, .vector_addr_out, .in_service_out);

// ==== tb/tlig_core_model.sv ====
/*
 core sequencer model: acks a pending request after a wait and
 returns from the handler after a second wait (zero: never returns).
 assumes the block samples on the rising edge.
*/
module tlig_core_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic busy_in,
	input wire logic [3:0] ack_wait_in,
	input wire logic [3:0] ret_wait_in,
	output logic ack_out,
	output logic ret_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	////////////////////////////////////////////////////////////
	// acts on the falling edge so the block sees settled strobes
	always @(negedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 4'h0;
			ack_out <= 1'b0;
			ret_out <= 1'b0;
		end else begin
			ack_out <= 1'b0;
			ret_out <= 1'b0;
			cnt <= cnt + 4'h1;
			if (req_in && cnt >= ack_wait_in) begin
				ack_out <= 1'b1;
				cnt <= 4'h0;
			end else if (busy_in && ret_wait_in != 4'h0) begin
				// handler exit by return; pop-and-clear is driven by the bench
				if (cnt >= ret_wait_in) begin
					ret_out <= 1'b1;
					cnt <= 4'h0;
				end
			end else if (!req_in) begin
				cnt <= 4'h0;
			end
		end
	end
endmodule

// ==== tb/tb_top.sv ====
/*
 self-checking bench for the interrupt gating top with a core model.
 assumes inputs change on the falling edge, outputs settle by then.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tlig_pkg::*;
	logic clk_in, rst_in, vector_wr_in, core_ack_in, return_op_in;
	logic in_service_clr_in, int_req_out, vector_take_out, in_service_out;
	tlig_src_type flag_event_in, flag_set_sw_in, flag_clr_sw_in, flags_out;
	tlig_en_type enables_in;
	logic [7:0] module_mask_in, int_control_in, module_req_out;
	logic [7:0] ext_flag_lo_out, ext_flag_hi_out, watchdog_flags_out;
	logic [7:0] rtc_flags_out, serial0_flags_out, serial1_flags_out;
	logic [7:0] spi_flags_out, timer0_flags_out, timer1_flags_out;
	logic [15:0] vector_data_in, vector_addr_out;
	logic [3:0] ack_wait, ret_wait;
	logic [71:0] views;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	assign views = {timer1_flags_out, timer0_flags_out, spi_flags_out,
		serial1_flags_out, serial0_flags_out, rtc_flags_out,
		watchdog_flags_out, ext_flag_hi_out, ext_flag_lo_out};
	tlig_top dut (.clk_in, .rst_in, .flag_event_in, .flag_set_sw_in,
		.flag_clr_sw_in, .enables_in, .module_mask_in, .int_control_in,
		.vector_wr_in, .vector_data_in, .core_ack_in, .return_op_in,
		.in_service_clr_in, .flags_out, .ext_flag_lo_out, .ext_flag_hi_out,
		.watchdog_flags_out, .rtc_flags_out, .serial0_flags_out,
		.serial1_flags_out, .spi_flags_out, .timer0_flags_out,
		.timer1_flags_out, .module_req_out, .int_req_out, .vector_take_out,
		.vector_addr_out, .in_service_out);
	tlig_core_model core (.clk_in, .rst_in, .req_in(int_req_out),
		.busy_in(in_service_out), .ack_wait_in(ack_wait),
		.ret_wait_in(ret_wait), .ack_out(core_ack_in), .ret_out(return_op_in));
	////////////////////////////////////////////////////////////
	task automatic check(input logic [71:0] seen, input logic [71:0] exp,
		input string what);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// which module mask bit gates a single source
	function automatic int exp_mod(input tlig_src_type s);
		if (s.wdog) return MASK_SYSTEM_BIT;
		if (s.ext_hi != 8'h00) return MASK_MOD1_BIT;
		if (s.ser0_rx || s.ser0_tx) return MASK_MOD2_BIT;
		if (s.t1_low_cmp || s.t1_low_ovf) return MASK_MOD4_BIT;
		if (s.ext_lo != 8'h00 || s.tod_alarm || s.subsec_alarm)
			return MASK_MOD0_BIT;
		return MASK_MOD3_BIT;
	endfunction
	// where each flag must appear in the peripheral register views
	function automatic logic [71:0] exp_view(input tlig_src_type s);
		return {5'h00, s.t1_low_ovf, 1'b0, s.t1_low_cmp, 4'h0, s.t0_ovf,
			s.t0_low_ovf, s.t0_capt, s.t0_low_cmp, 1'b0, s.spi_done,
			s.spi_overrun, s.spi_collide, s.spi_fault, 3'h0, 6'h00,
			s.ser1_tx, s.ser1_rx, 6'h00, s.ser0_tx, s.ser0_rx,
			s.subsec_alarm, s.tod_alarm, 6'h00, 4'h0, s.wdog, 3'h0,
			s.ext_hi, s.ext_lo};
	endfunction
	task automatic wait_take;
		for (int n = 0; n < 12 && vector_take_out !== 1'b1; n++)
			@(negedge clk_in);
		check(vector_take_out, 1'b1, "vector taken");
		check(in_service_out, 1'b1, "in service set");
		check(vector_addr_out, 16'hA5C3, "vector used");
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		check(vector_addr_out, VECTOR_RESET, "vector reset");
		check({int_req_out, in_service_out, flags_out}, '0, "reset");
		$display("test reset done");
	endtask
	task automatic t_vector;
		vector_wr_in = 1'b1;
		vector_data_in = 16'hA5C3;
		@(negedge clk_in);
		vector_wr_in = 1'b0;
		vector_data_in = 16'h0F0F;
		check(vector_addr_out, 16'hA5C3, "vector load");
		@(negedge clk_in);
		check(vector_addr_out, 16'hA5C3, "vector hold");
		$display("test vector done");
	endtask
	// each source alone, set by hardware or software in turn
	task automatic t_sources;
		logic [$bits(tlig_src_type)-1:0] v;
		tlig_src_type s;
		enables_in = '1;
		module_mask_in = 8'hFF;
		int_control_in = 8'h00;
		for (int i = 0; i < $bits(tlig_src_type); i++) begin
			v = '0;
			v[i] = 1'b1;
			s = v;
			if (i % 2 == 1)
				flag_set_sw_in = s;
			else
				flag_event_in = s;
			@(negedge clk_in);
			flag_set_sw_in = '0;
			flag_event_in = '0;
			check(flags_out, s, "flag set");
			check(views, exp_view(s), "flag view");
			@(negedge clk_in);
			check(module_req_out, 8'h01 << exp_mod(s),
				"module req");
			enables_in = '0;
			repeat (2) @(negedge clk_in);
			check(module_req_out, 8'h00, "local enable off");
			enables_in = '1;
			module_mask_in = ~(8'h01 << exp_mod(s));
			repeat (2) @(negedge clk_in);
			check(module_req_out, 8'h00, "module mask off");
			check(flags_out, s, "flag kept");
			module_mask_in = 8'hFF;
			flag_clr_sw_in = s;
			// a clear that meets a set in one cycle must lose
			flag_event_in = s;
			@(negedge clk_in);
			flag_event_in = '0;
			check(flags_out, s, "set beats clear");
			@(negedge clk_in);
			flag_clr_sw_in = '0;
			check(flags_out, '0, "flag cleared");
		end
		$display("test sources done");
	endtask
	// two sources at once, nesting, then exit through return
	task automatic t_service;
		int_control_in = 8'hFE;
		ack_wait = 4'h4;
		flag_event_in.ext_lo[3] = 1'b1;
		flag_event_in.wdog = 1'b1;
		@(negedge clk_in);
		flag_event_in = '0;
		repeat (4) @(negedge clk_in);
		check(int_req_out, 1'b0, "global enable off");
		int_control_in = 8'h01;
		wait_take();
		repeat (3) @(negedge clk_in);
		check(int_req_out, 1'b0, "held off in service");
		ack_wait = 4'h0;
		in_service_clr_in = 1'b1;
		@(negedge clk_in);
		in_service_clr_in = 1'b0;
		check(in_service_out, 1'b0, "nest clear");
		wait_take();
		flag_clr_sw_in = flags_out;
		ret_wait = 4'h3;
		@(negedge clk_in);
		flag_clr_sw_in = '0;
		for (int n = 0; n < 12 && in_service_out !== 1'b0; n++)
			@(negedge clk_in);
		check(in_service_out, 1'b0, "return clears");
		repeat (3) @(negedge clk_in);
		check(int_req_out, 1'b0, "no request after clear");
		$display("test service done");
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		rst_in = 1'b1;
		flag_event_in = '0;
		flag_set_sw_in = '0;
		flag_clr_sw_in = '0;
		enables_in = '0;
		module_mask_in = 8'h00;
		int_control_in = 8'h00;
		vector_wr_in = 1'b0;
		vector_data_in = 16'h0000;
		in_service_clr_in = 1'b0;
		ack_wait = 4'h1;
		ret_wait = 4'h0;
		repeat (6) @(negedge clk_in);
		rst_in = 1'b0;
		t_reset();
		t_vector();
		t_sources();
		t_service();
		wrap_up();
	end
endmodule
